// ===== pcmc_pkg.sv
/*
  Shared constants and carriers for the power and clock mode controller.
  Assumes a 32-bit APB register bus and a single 250 MHz reference clock.
*/
`default_nettype none
package pcmc_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0]  PCMC_OFF_PWR    = 8'h00;
  localparam logic [7:0]  PCMC_OFF_SLOW   = 8'h04;
  localparam logic [7:0]  PCMC_OFF_RADIO  = 8'h08;
  localparam logic [7:0]  PCMC_OFF_MODEM  = 8'h0c;
  localparam logic [7:0]  PCMC_OFF_EXTINT = 8'h10;
  localparam logic [7:0]  PCMC_OFF_STATUS = 8'h14;
  // ==========================================================
  // Field positions and reset values
  localparam int          PCMC_RANGE_W    = 3;
  localparam logic [15:0] PCMC_RESET_VEC  = 16'h0000;
  localparam int          PCMC_SYNC_DEPTH = 3;
  localparam int          PCMC_SW_TICKS   = 2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic smod0;
    logic gf1;
    logic gf0;
    logic stop;
    logic idle;
  } pcmc_pwr_t;
  localparam pcmc_pwr_t   PCMC_PWR_RST    = '{default: 1'b0};

  typedef struct packed {
    logic bypass;
    logic powerdown;
    logic cmode;
  } pcmc_slow_t;
  localparam pcmc_slow_t  PCMC_SLOW_RST   = '{bypass: 1'b0, powerdown: 1'b1, cmode: 1'b0};

  typedef struct packed {
    logic rx_req;
    logic main_osc_bias_powerdown;
    logic main_osc_core_powerdown;
  } pcmc_radio_t;
  localparam pcmc_radio_t PCMC_RADIO_RST  = '{default: 1'b0};

  typedef enum logic [1:0] {
    PCMC_ACTIVE = 2'b00,
    PCMC_IDLE   = 2'b01,
    PCMC_STOP   = 2'b10
  } pcmc_state_t;
endpackage
`default_nettype wire

// ===== pcmc_pin_sync.sv
/*
  Three-stage synchroniser for pins from outside the ref_clk domain.
  The level changes only once stages two and three agree; rise and fall
  are one-cycle pulses. Assumes an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pcmc_pin_sync
  import pcmc_pkg::*;
#(
  parameter int W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  // Pins and result
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level_ff,
  output var  logic [W-1:0] rise_ff,
  output var  logic [W-1:0] fall_ff
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_level = (agree & s3_ff) | (~agree & level_ff);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff    <= RST_VAL;
      s2_ff    <= RST_VAL;
      s3_ff    <= RST_VAL;
      level_ff <= RST_VAL;
      rise_ff  <= '0;
      fall_ff  <= '0;
    end else begin
      s1_ff    <= pin_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
      rise_ff  <= nxt_level & ~level_ff;
      fall_ff  <= ~nxt_level & level_ff;
    end
  end
endmodule
`default_nettype wire

// ===== pcmc_clk_switch.sv
/*
  Glitch-free selection between main and slow oscillator ticks.
  Ticks are one-cycle pulses marking rising edges of each oscillator.
  Assumes sel is a register of the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pcmc_clk_switch
  import pcmc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic soft_clr,
  // Oscillator ticks and select
  input  wire logic main_tick,
  input  wire logic slow_tick,
  input  wire logic sel,
  // Result
  output var  logic mode_ff,
  output var  logic busy_ff,
  output var  logic tick_ff
);
  logic       old_off_ff;
  logic [1:0] cnt_ff;
  wire        old_tick = mode_ff ? slow_tick : main_tick;
  wire        new_tick = mode_ff ? main_tick : slow_tick;
  wire        req      = sel != mode_ff;
  wire        done     = old_off_ff && new_tick && (cnt_ff == 2'(PCMC_SW_TICKS - 1));

  // The old source is stopped on its own edge before the new one is counted,
  // so no shortened period is ever passed on.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      old_off_ff <= 1'b0;
      cnt_ff     <= 2'h0;
      tick_ff    <= 1'b0;
    end else if (soft_clr) begin
      mode_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      old_off_ff <= 1'b0;
      cnt_ff     <= 2'h0;
      tick_ff    <= 1'b0;
    end else begin
      busy_ff <= req && !done;
      tick_ff <= !req && old_tick; // R22
      if (!req) begin
        old_off_ff <= 1'b0;
        cnt_ff     <= 2'h0;
      end else if (!old_off_ff) begin
        old_off_ff <= old_tick; // R22
      end else if (new_tick) begin
        cnt_ff <= cnt_ff + 2'h1; // R15 R21
        if (done) begin
          mode_ff    <= sel;
          old_off_ff <= 1'b0;
          cnt_ff     <= 2'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== pcmc_top.sv
/*
  Power and clock mode controller: idle and power-down sequencing, clock tree
  enables, external interrupt capture and glitch-free clock mode switching.
  Assumes an APB master, a core that pulses instr_done per instruction and
  reports enabled pending interrupts, and oscillator outputs as plain pins.
*/
// What this block does
// [R01] Idle after the requesting instruction: core halts, state kept, peripherals run.
// [R02] An enabled interrupt in idle clears the idle bit and ends idle.
// [R03] After the service routine, execution resumes after the idle instruction.
// [R04] Any reset in idle or power-down clears registers; fetch restarts at zero.
// [R05] Power-down stops core and peripheral clocks; converter clock keeps running.
// [R06] In power-down the converter may raise a reset that ends it.
// [R07] The stop bit never switches off either oscillator.
// [R08] Power-down ends only through reset or power cycle, never interrupts.
// [R09] External pins wake from idle but not from power-down.
// [R10] Enabled external pulses longer than eight cycles always set a request.
// [R11] Select bit 0 picks the main crystal clock, 1 the slow clock.
// [R12] After reset: main clock running, slow oscillator powered down.
// [R13] Software powers the slow oscillator up 160 ms before selecting it.
// [R14] Bypass takes an external slow clock from the slow oscillator pin.
// [R15] Switch to slow clock is glitch-free within two to three slow periods.
// [R16] Software may power down the main oscillator only while on the slow clock.
// [R17] The receiver cannot be activated while the slow clock is selected.
// [R18] Software programs the 3-bit crystal range code to match the crystal.
// [R19] For least current software turns converter and oscillators off instead.
// [R20] On the slow clock software should combine idle with flash power control.
// [R21] Return to main clock: power up, wait 5 ms, clear select; 2-3 periods.
// [R22] Select is synchronised; old clock stops before the new clock starts.
`timescale 1ns/1ps
`default_nettype none
module pcmc_top
  import pcmc_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata_ff,
  output var  logic                    pready_ff,
  output var  logic                    pslverr_ff,
  // Core handshake
  input  wire logic                    instr_done,
  input  wire logic                    core_irq_req,
  input  wire logic                    adc_reset_req,
  output var  logic                    core_halt_ff,
  output var  logic                    idle_wake_ff,
  output var  logic                    fetch_restart_ff,
  output var  logic [15:0]             restart_vector_ff,
  // Oscillator pins
  input  wire logic                    main_osc_pin,
  input  wire logic                    slow_osc_internal,
  input  wire logic                    slow_osc_input_pin,
  output var  logic                    slow_osc_powerdown_ff,
  output var  logic                    slow_osc_bypass_ff,
  output var  logic                    main_osc_core_powerdown_ff,
  output var  logic                    main_osc_bias_powerdown_ff,
  // Clock tree enables
  output var  logic                    core_clk_en_ff,
  output var  logic                    periph_clk_en_ff,
  output var  logic                    adc_clk_en_ff,
  // External interrupts and radio
  input  wire logic [1:0]              ext_int_n_pin,
  output var  logic [1:0]              ext_irq_ff,
  output var  logic                    rx_enable_ff,
  output var  logic [PCMC_RANGE_W-1:0] crystal_range_code_ff
);
  // ==========================================================
  // Register state
  pcmc_pwr_t                power_control_reg_ff;
  pcmc_slow_t               slow_osc_control_reg_ff;
  pcmc_radio_t              radio_main_control_reg_ff;
  logic [PCMC_RANGE_W-1:0]  modem_config_reg_ff;
  logic [3:0]               ext_ctrl_ff;
  pcmc_state_t              state_ff;
  logic                     soft_clr_ff;

  // ==========================================================
  // Bus decode
  wire        bus_access = psel && penable;
  wire        wr_go      = bus_access && pready_ff && pwrite;
  wire        hit_pwr    = paddr == PCMC_OFF_PWR;
  wire        hit_slow   = paddr == PCMC_OFF_SLOW;
  wire        hit_radio  = paddr == PCMC_OFF_RADIO;
  wire        hit_modem  = paddr == PCMC_OFF_MODEM;
  wire        hit_ext    = paddr == PCMC_OFF_EXTINT;
  wire        hit_stat   = paddr == PCMC_OFF_STATUS;
  wire        mapped     = hit_pwr | hit_slow | hit_radio | hit_modem | hit_ext | hit_stat;
  wire        wr_pwr     = wr_go && hit_pwr;
  wire        wr_slow    = wr_go && hit_slow;
  wire        wr_radio   = wr_go && hit_radio;
  wire        wr_modem   = wr_go && hit_modem;
  wire        wr_ext     = wr_go && hit_ext;

  // ==========================================================
  // Pins and oscillator ticks
  logic       main_tick;
  logic       slow_tick;
  logic [1:0] ext_lvl;
  logic [1:0] ext_fall;
  logic       sw_mode;
  logic       sw_busy;
  logic       sys_tick;
  wire        slow_src = slow_osc_control_reg_ff.bypass ? slow_osc_input_pin : slow_osc_internal; // R14

  pcmc_pin_sync #(.W(2), .RST_VAL(2'h0)) u_osc_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pin_in   ({slow_src, main_osc_pin}),
    .level_ff (),
    .rise_ff  ({slow_tick, main_tick}),
    .fall_ff  ()
  );

  pcmc_pin_sync #(.W(2), .RST_VAL(2'h3)) u_ext_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pin_in   (ext_int_n_pin),
    .level_ff (ext_lvl),
    .rise_ff  (),
    .fall_ff  (ext_fall)
  );

  // A powered-down source gives no ticks; bypass ignores the slow power-down.
  wire main_ok   = !(radio_main_control_reg_ff.main_osc_core_powerdown || radio_main_control_reg_ff.main_osc_bias_powerdown);
  wire slow_ok   = !slow_osc_control_reg_ff.powerdown || slow_osc_control_reg_ff.bypass;

  pcmc_clk_switch u_switch (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .soft_clr  (soft_clr_ff),
    .main_tick (main_tick && main_ok),
    .slow_tick (slow_tick && slow_ok),
    .sel       (slow_osc_control_reg_ff.cmode), // R11
    .mode_ff   (sw_mode),
    .busy_ff   (sw_busy),
    .tick_ff   (sys_tick)
  );

  // ==========================================================
  // External interrupt capture
  // Enable bits [1:0], edge mode bits [3:2]; flags clear by writing one to [5:4].
  // The synchroniser catches any low pulse of two or more cycles, well inside eight.
  wire [1:0] ext_en     = ext_ctrl_ff[1:0];
  wire [1:0] ext_edge   = ext_ctrl_ff[3:2];
  wire [1:0] ext_set    = ext_en & ((ext_edge & ext_fall) | (~ext_edge & ~ext_lvl)); // R10
  wire [1:0] ext_clr    = {2{wr_ext}} & pwdata[5:4];
  wire [1:0] nxt_ext    = ext_set | (ext_irq_ff & ~ext_clr);

  // ==========================================================
  // Power state sequencing
  wire         reset_evt   = adc_reset_req; // R04 R06
  wire         wake        = core_irq_req || (|(ext_irq_ff & ext_en)); // R02 R09
  pcmc_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PCMC_ACTIVE: begin
        if (instr_done && power_control_reg_ff.stop) begin
          nxt_state = PCMC_STOP; // R05
        end else if (instr_done && power_control_reg_ff.idle) begin
          nxt_state = PCMC_IDLE; // R01
        end
      end
      PCMC_IDLE: begin
        if (wake) begin
          nxt_state = PCMC_ACTIVE; // R02
        end
      end
      PCMC_STOP: begin
        nxt_state = PCMC_STOP; // R08
      end
      default: begin
        nxt_state = PCMC_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff         <= PCMC_ACTIVE;
      soft_clr_ff      <= 1'b0;
      idle_wake_ff     <= 1'b0;
      fetch_restart_ff <= 1'b0;
    end else begin
      soft_clr_ff      <= reset_evt;
      fetch_restart_ff <= soft_clr_ff; // R04
      idle_wake_ff     <= !reset_evt && state_ff == PCMC_IDLE && wake; // R03
      state_ff         <= reset_evt ? PCMC_ACTIVE : nxt_state;
    end
  end

  // ==========================================================
  // Software registers
  // The stop bit touches neither oscillator power-down; those follow software writes and converter resets only.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_control_reg_ff      <= PCMC_PWR_RST;
      slow_osc_control_reg_ff   <= PCMC_SLOW_RST; // R12
      radio_main_control_reg_ff <= PCMC_RADIO_RST;
      modem_config_reg_ff       <= '0;
      ext_ctrl_ff               <= 4'h0;
      ext_irq_ff                <= 2'h0;
    end else if (soft_clr_ff) begin
      power_control_reg_ff      <= PCMC_PWR_RST; // R04
      slow_osc_control_reg_ff   <= PCMC_SLOW_RST;
      radio_main_control_reg_ff <= PCMC_RADIO_RST;
      modem_config_reg_ff       <= '0;
      ext_ctrl_ff               <= 4'h0;
      ext_irq_ff                <= 2'h0;
    end else begin
      ext_irq_ff <= nxt_ext;
      if (wr_pwr) begin
        power_control_reg_ff <= pcmc_pwr_t'({pwdata[7], pwdata[3:0]});
      end else if (state_ff == PCMC_IDLE && wake) begin
        power_control_reg_ff.idle <= 1'b0; // R02
      end
      if (wr_slow) begin
        slow_osc_control_reg_ff <= pcmc_slow_t'(pwdata[2:0]); // R07
      end
      if (wr_radio) begin
        radio_main_control_reg_ff <= pcmc_radio_t'(pwdata[2:0]);
      end
      if (wr_modem) begin
        modem_config_reg_ff <= pwdata[PCMC_RANGE_W-1:0];
      end
      if (wr_ext) begin
        ext_ctrl_ff <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // Read mux and APB answer
  logic [31:0] rd_data;
  assign rd_data =
      hit_pwr   ? {24'h0, power_control_reg_ff.smod0, 3'h3, power_control_reg_ff.gf1,
                   power_control_reg_ff.gf0, power_control_reg_ff.stop, power_control_reg_ff.idle} :
      hit_slow  ? {29'h0, slow_osc_control_reg_ff} :
      hit_radio ? {29'h0, radio_main_control_reg_ff} :
      hit_modem ? {{(32 - PCMC_RANGE_W){1'b0}}, modem_config_reg_ff} :
      hit_ext   ? {26'h0, ext_irq_ff, ext_ctrl_ff} :
      hit_stat  ? {28'h0, sw_busy, sw_mode, state_ff} :
                  32'h0000_0000;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= bus_access && !pready_ff;
      pslverr_ff <= bus_access && !pready_ff && !mapped;
      if (bus_access && !pready_ff) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // ==========================================================
  // Clock tree enables and pin-facing outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_halt_ff               <= 1'b0;
      core_clk_en_ff             <= 1'b0;
      periph_clk_en_ff           <= 1'b0;
      adc_clk_en_ff              <= 1'b0;
      rx_enable_ff               <= 1'b0;
      restart_vector_ff          <= PCMC_RESET_VEC;
      slow_osc_powerdown_ff      <= 1'b1;
      slow_osc_bypass_ff         <= 1'b0;
      main_osc_core_powerdown_ff <= 1'b0;
      main_osc_bias_powerdown_ff <= 1'b0;
      crystal_range_code_ff      <= '0;
    end else begin
      core_halt_ff               <= state_ff != PCMC_ACTIVE; // R01 R05
      core_clk_en_ff             <= sys_tick && state_ff == PCMC_ACTIVE;
      periph_clk_en_ff           <= sys_tick && state_ff != PCMC_STOP; // R01 R05
      adc_clk_en_ff              <= sys_tick; // R05 R06
      rx_enable_ff               <= radio_main_control_reg_ff.rx_req &&
                                    !sw_mode && !slow_osc_control_reg_ff.cmode; // R17
      restart_vector_ff          <= PCMC_RESET_VEC; // R04
      slow_osc_powerdown_ff      <= slow_osc_control_reg_ff.powerdown; // R07 R12
      slow_osc_bypass_ff         <= slow_osc_control_reg_ff.bypass; // R14
      main_osc_core_powerdown_ff <= radio_main_control_reg_ff.main_osc_core_powerdown; // R07
      main_osc_bias_powerdown_ff <= radio_main_control_reg_ff.main_osc_bias_powerdown;
      crystal_range_code_ff      <= modem_config_reg_ff;
    end
  end
endmodule
`default_nettype wire

// ===== pcmc_assertions.sv
/*
  Concurrent checks on the ports of the power and clock mode controller.
  Assumes it is bound to pcmc_top and clocked by its ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pcmc_assertions
  import pcmc_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // Bus and core side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  input wire logic        adc_reset_req,
  input wire logic        core_halt_ff,
  input wire logic        idle_wake_ff,
  input wire logic        fetch_restart_ff,
  input wire logic [15:0] restart_vector_ff,
  // Clock side
  input wire logic        core_clk_en_ff,
  input wire logic        periph_clk_en_ff,
  input wire logic        slow_osc_powerdown_ff,
  input wire logic        main_osc_core_powerdown_ff
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_apb_answer: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("access not answered in the next cycle");
  a_pready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("pready held longer than one cycle");
  a_slverr_qual: assert property (pslverr_ff |-> pready_ff)
    else $error("slave error without pready");
  a_halt_core_off: assert property (core_halt_ff |-> !core_clk_en_ff)
    else $error("core clock enabled while halted");
  a_wake_resume: assert property (idle_wake_ff |-> ##[0:2] !core_halt_ff)
    else $error("core still halted after wake");
  a_restart_soon: assert property ($rose(adc_reset_req) |-> ##[1:3] fetch_restart_ff)
    else $error("no fetch restart after converter reset");
  a_restart_vec: assert property (fetch_restart_ff |-> restart_vector_ff == 16'h0000)
    else $error("restart vector not zero");
  a_stop_osc_keep: assert property ($rose(core_halt_ff) |->
      $stable(slow_osc_powerdown_ff) && $stable(main_osc_core_powerdown_ff))
    else $error("oscillator control changed on halt entry");
  a_periph_pulse: assert property (periph_clk_en_ff |=> !periph_clk_en_ff)
    else $error("peripheral enable wider than one cycle");
endmodule
`default_nettype wire

// ===== pcmc_top_tb.sv
/*
  Self-checking bench for pcmc_top: register table, idle and power-down
  entry and exit, and clock mode switching.
  Assumes the package, design and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module pcmc_top_tb
  import pcmc_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } pcmc_row_t;
  // ==========================================================
  // Signals
  logic        ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        instr_done = 1'b0, core_irq_req = 1'b0, adc_reset_req = 1'b0;
  logic        main_osc_pin = 1'b0, slow_osc_internal = 1'b0, slow_osc_input_pin = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_ff, q;
  logic [1:0]  ext_int_n_pin = 2'b11, ext_irq_ff;
  logic [15:0] restart_vector_ff;
  logic [2:0]  crystal_range_code_ff;
  logic        pready_ff, pslverr_ff, core_halt_ff, idle_wake_ff, fetch_restart_ff, e;
  logic        slow_osc_powerdown_ff, slow_osc_bypass_ff, main_osc_core_powerdown_ff;
  logic        main_osc_bias_powerdown_ff, core_clk_en_ff, periph_clk_en_ff, adc_clk_en_ff, rx_enable_ff;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, n, t0, cnt[3];
  pcmc_row_t   rows [10] = '{
    '{1'b0, PCMC_OFF_PWR, 32'h0, 32'h30, 1'b0},
    '{1'b0, PCMC_OFF_SLOW, 32'h0, 32'h02, 1'b0},
    '{1'b0, PCMC_OFF_STATUS, 32'h0, 32'h00, 1'b0},
    '{1'b1, PCMC_OFF_PWR, 32'h8c, 32'hbc, 1'b0},
    '{1'b1, PCMC_OFF_SLOW, 32'h06, 32'h06, 1'b0},
    '{1'b1, PCMC_OFF_RADIO, 32'h03, 32'h03, 1'b0},
    '{1'b1, PCMC_OFF_MODEM, 32'hff, 32'h07, 1'b0},
    '{1'b1, PCMC_OFF_EXTINT, 32'h0f, 32'h0f, 1'b0},
    '{1'b1, 8'h18, 32'hff, 32'h00, 1'b1},
    '{1'b1, PCMC_OFF_STATUS, 32'hff, 32'h00, 1'b0}
  };

  pcmc_top u_dut (
    .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
    .pslverr_ff, .instr_done, .core_irq_req, .adc_reset_req, .core_halt_ff, .idle_wake_ff,
    .fetch_restart_ff, .restart_vector_ff, .main_osc_pin, .slow_osc_internal, .slow_osc_input_pin,
    .slow_osc_powerdown_ff, .slow_osc_bypass_ff, .main_osc_core_powerdown_ff,
    .main_osc_bias_powerdown_ff, .core_clk_en_ff, .periph_clk_en_ff, .adc_clk_en_ff,
    .ext_int_n_pin, .ext_irq_ff, .rx_enable_ff, .crystal_range_code_ff
  );

  // ==========================================================
  // Clock and oscillators
  always #2 ref_clk = ~ref_clk;
  // Distinct periods (8, 40, 24 cycles) let enable spacing reveal the selected source.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    main_osc_pin <= (cyc % 8) < 4;
    slow_osc_internal <= (cyc % 40) < 20;
    slow_osc_input_pin <= (cyc % 24) < 12;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // Starts on a fresh edge so psel is never driven twice in one time step.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready_ff !== 1'b1 && k < 20);
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready_ff !== 1'b1) error_cnt++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic step_instr();
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
  endtask
  task automatic gap(input int exp);
    int k;
    for (k = 0; k < 100 && periph_clk_en_ff !== 1'b1; k++) @(posedge ref_clk);
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (periph_clk_en_ff !== 1'b1 && k < 100);
    chk(32'(k), 32'(exp));
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    complete_run();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk1(slow_osc_powerdown_ff, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].exp);
      chk1(e, rows[i].err);
    end
    $display("register test done");
    chk(32'(crystal_range_code_ff), 32'h7);
    wr(PCMC_OFF_SLOW, 32'h0);
    // The register rows left the main oscillator powered down; idle needs its ticks.
    wr(PCMC_OFF_RADIO, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(PCMC_OFF_PWR, 32'h8d);
      step_instr();
      for (n = 0; n < 50 && core_halt_ff !== 1'b1; n++) @(posedge ref_clk);
      chk1(core_halt_ff, 1'b1);
      for (n = 0; n < 50 && periph_clk_en_ff !== 1'b1; n++) @(posedge ref_clk);
      chk1(periph_clk_en_ff, 1'b1);
      if (i == 0) ext_int_n_pin <= 2'b10;
      else core_irq_req <= 1'b1;
      for (n = 0; n < 60 && idle_wake_ff !== 1'b1; n++) begin
        @(posedge ref_clk);
        if (n == 9) ext_int_n_pin <= 2'b11;
      end
      chk1(idle_wake_ff, 1'b1);
      repeat (3) @(posedge ref_clk);
      ext_int_n_pin <= 2'b11;
      core_irq_req <= 1'b0;
      chk1(core_halt_ff, 1'b0);
      rd(PCMC_OFF_PWR, 32'hbc);
      if (i == 0) begin
        chk1(ext_irq_ff[0], 1'b1);
        // Level mode from here on, so the stop test holds both flags up.
        wr(PCMC_OFF_EXTINT, 32'h13);
        rd(PCMC_OFF_EXTINT, 32'h03);
      end
    end
    $display("idle test done");
    wr(PCMC_OFF_PWR, 32'h02);
    step_instr();
    for (n = 0; n < 50 && core_halt_ff !== 1'b1; n++) @(posedge ref_clk);
    // Wake sources are held active across the whole stop window on purpose.
    core_irq_req <= 1'b1;
    ext_int_n_pin <= 2'b00;
    cnt = '{0, 0, 0};
    repeat (100) begin
      @(posedge ref_clk);
      cnt[0] += core_clk_en_ff;
      cnt[1] += periph_clk_en_ff;
      cnt[2] += adc_clk_en_ff;
    end
    chk(32'(cnt[0] + cnt[1]), 32'h0);
    chk1(cnt[2] > 0, 1'b1);
    chk1(core_halt_ff, 1'b1);
    chk(32'(ext_irq_ff), 32'h3);
    chk1(slow_osc_powerdown_ff, 1'b0);
    core_irq_req <= 1'b0;
    ext_int_n_pin <= 2'b11;
    adc_reset_req <= 1'b1;
    @(posedge ref_clk);
    adc_reset_req <= 1'b0;
    for (n = 0; n < 10 && fetch_restart_ff !== 1'b1; n++) @(posedge ref_clk);
    chk1(fetch_restart_ff, 1'b1);
    chk(32'(restart_vector_ff), 32'h0);
    repeat (3) @(posedge ref_clk);
    chk1(core_halt_ff, 1'b0);
    rd(PCMC_OFF_PWR, 32'h30);
    rd(PCMC_OFF_SLOW, 32'h02);
    $display("power-down test done");
    wr(PCMC_OFF_RADIO, 32'h04);
    wr(PCMC_OFF_SLOW, 32'h00);
    chk1(rx_enable_ff, 1'b1);
    gap(8);
    repeat (50) @(posedge ref_clk);
    wr(PCMC_OFF_SLOW, 32'h01);
    t0 = cyc;
    for (n = 0; n < 60; n++) begin
      apb(1'b0, PCMC_OFF_STATUS, 32'h0);
      if (q[2] === 1'b1) break;
    end
    chk1(cyc - t0 < 160, 1'b1);
    chk(q, 32'h04);
    chk1(rx_enable_ff, 1'b0);
    gap(40);
    wr(PCMC_OFF_RADIO, 32'h07);
    repeat (2) @(posedge ref_clk);
    chk({30'h0, main_osc_core_powerdown_ff, main_osc_bias_powerdown_ff}, 32'h3);
    chk1(rx_enable_ff, 1'b0);
    wr(PCMC_OFF_PWR, 32'h01);
    step_instr();
    core_irq_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk1(idle_wake_ff, 1'b1);
    core_irq_req <= 1'b0;
    wr(PCMC_OFF_SLOW, 32'h05);
    repeat (150) @(posedge ref_clk);
    chk1(slow_osc_bypass_ff, 1'b1);
    gap(24);
    wr(PCMC_OFF_RADIO, 32'h04);
    wr(PCMC_OFF_SLOW, 32'h00);
    repeat (150) @(posedge ref_clk);
    gap(8);
    chk1(rx_enable_ff, 1'b1);
    $display("clock mode test done");
    complete_run();
  end
endmodule

bind pcmc_top pcmc_assertions u_chk (
  .ref_clk, .reset_n, .psel, .penable, .pready_ff, .pslverr_ff, .adc_reset_req, .core_halt_ff,
  .idle_wake_ff, .fetch_restart_ff, .restart_vector_ff, .core_clk_en_ff, .periph_clk_en_ff,
  .slow_osc_powerdown_ff, .main_osc_core_powerdown_ff
);
`default_nettype wire
